// *** gpp_pkg.sv ***
package gpp_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int unsigned GPP_ADDR_W = 2;
    localparam int unsigned GPP_DATA_W = 8;
    localparam int unsigned GPP_PIN_N  = 6;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [GPP_ADDR_W-1:0] GPP_OFS_PIN_VALUE = 2'h0;
    localparam logic [GPP_ADDR_W-1:0] GPP_OFS_DIRECTION = 2'h1;
    localparam logic [GPP_ADDR_W-1:0] GPP_OFS_OUT_LATCH = 2'h2;
    localparam logic [GPP_ADDR_W-1:0] GPP_OFS_ANA_SEL   = 2'h3;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int unsigned                 GPP_INPUT_ONLY_IDX = 3;
    localparam logic [GPP_PIN_N-1:0]        GPP_INPUT_ONLY_MSK = 6'h08;
    localparam logic [GPP_PIN_N-1:0]        GPP_DIR_RST        = 6'h3F;
    localparam logic [GPP_PIN_N-1:0]        GPP_LATCH_RST      = 6'h00;
    localparam logic [GPP_PIN_N-1:0]        GPP_ANA_RST        = 6'h3F;
    localparam logic [GPP_DATA_W-1:0]       GPP_RD_IDLE        = 8'h00;

    // ****************************************
    // synchroniser depth in cycles
    // ****************************************
    localparam int unsigned GPP_SYNC_STAGES = 2;

endpackage : gpp_pkg

// *** gpp_sync.sv ***
`timescale 1ns/1ps

// ****************************************
// two-stage level synchroniser
// ****************************************
module gpp_sync #(
    parameter int unsigned W = 6
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import gpp_pkg::*;

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage is read only by the second stage
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule : gpp_sync

// *** gpp_port.sv ***
`timescale 1ns/1ps

module gpp_port #(
    parameter int unsigned PIN_N = gpp_pkg::GPP_PIN_N
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic [gpp_pkg::GPP_ADDR_W-1:0] addr,
    input  wire logic [gpp_pkg::GPP_DATA_W-1:0] wr_data,
    input  wire logic [PIN_N-1:0]               wr_bits,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    output logic      [gpp_pkg::GPP_DATA_W-1:0] rd_data,
    input  wire logic [PIN_N-1:0]               pin_in,
    output logic      [PIN_N-1:0]               pin_out,
    output logic      [PIN_N-1:0]               pin_oe,
    output logic      [PIN_N-1:0]               ana_en
);
    import gpp_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [PIN_N-1:0]      dir_r;
    logic [PIN_N-1:0]      dir_nxt;
    logic [PIN_N-1:0]      lat_r;
    logic [PIN_N-1:0]      lat_nxt;
    logic [PIN_N-1:0]      ana_r;
    logic [PIN_N-1:0]      ana_nxt;
    logic [PIN_N-1:0]      oe_r;
    logic [PIN_N-1:0]      oe_nxt;
    logic [GPP_DATA_W-1:0] rdat_r;
    logic [GPP_DATA_W-1:0] rdat_nxt;

    // ****************************************
    // decode and input path
    // ****************************************
    logic [PIN_N-1:0]      pin_sync;
    logic [PIN_N-1:0]      pin_rd;
    logic [PIN_N-1:0]      wr_field;
    logic [PIN_N-1:0]      dir_view;
    logic [GPP_DATA_W-1:0] rd_mux;
    logic                  hit_pin;
    logic                  hit_dir;
    logic                  hit_lat;
    logic                  hit_ana;

    // zero-extend a pin vector into a bus word
    function automatic logic [GPP_DATA_W-1:0] gpp_widen(input logic [PIN_N-1:0] v);
        gpp_widen = {{(GPP_DATA_W-PIN_N){1'b0}}, v};
    endfunction : gpp_widen

    // port write merge: addressed bits come from the bus, the rest from the pins
    function automatic logic [PIN_N-1:0] gpp_merge(input logic [PIN_N-1:0] pins,
                                                   input logic [PIN_N-1:0] data,
                                                   input logic [PIN_N-1:0] bits);
        gpp_merge = (pins & ~bits) | (data & bits);
    endfunction : gpp_merge

    // pins are asynchronous to the core, so never read them raw
    gpp_sync #(
        .W (PIN_N)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (pin_in),
        .q       (pin_sync)
    );

    // address decode
    assign hit_pin  = (addr == GPP_OFS_PIN_VALUE);
    assign hit_dir  = (addr == GPP_OFS_DIRECTION);
    assign hit_lat  = (addr == GPP_OFS_OUT_LATCH);
    assign hit_ana  = (addr == GPP_OFS_ANA_SEL);
    assign wr_field = wr_data[PIN_N-1:0];

    // digital view of pins: analog-selected pins read as zero
    assign pin_rd   = pin_sync & ~ana_r;

    // input-only pin always reports input, whatever was written
    assign dir_view = dir_r | GPP_INPUT_ONLY_MSK;

    // read mux; four offsets cover the whole address space
    assign rd_mux = hit_pin ? gpp_widen(pin_rd) :
                    hit_dir ? gpp_widen(dir_view) :
                    hit_lat ? gpp_widen(lat_r) :
                              gpp_widen(ana_r);

    // ****************************************
    // next-state logic
    // ****************************************

    // direction writes; input-only bit is pinned high
    assign dir_nxt = (wr_en && hit_dir) ? (wr_field | GPP_INPUT_ONLY_MSK) : dir_r;

    // port write merges sampled pins with the addressed bits; an analog pin
    // not addressed reads zero and so loses its latch value, a known hazard
    assign lat_nxt = (wr_en && hit_pin) ? gpp_merge(pin_rd, wr_field, wr_bits) :
                     (wr_en && hit_lat) ? wr_field :
                                          lat_r;

    // analog select, plain read/write
    assign ana_nxt = (wr_en && hit_ana) ? wr_field : ana_r;

    // driver enable depends on direction only, never on analog select
    assign oe_nxt  = ~dir_nxt & ~GPP_INPUT_ONLY_MSK;

    // read data valid for exactly one cycle after the strobe
    assign rdat_nxt = rd_en ? rd_mux : GPP_RD_IDLE;

    // ****************************************
    // registers
    // ****************************************

    // all pins start as inputs in analog mode
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            dir_r <= GPP_DIR_RST;
            ana_r <= GPP_ANA_RST;
            lat_r <= GPP_LATCH_RST;
            oe_r  <= '0;
        end
        else
        begin
            dir_r <= dir_nxt;
            ana_r <= ana_nxt;
            lat_r <= lat_nxt;
            oe_r  <= oe_nxt;
        end
    end

    // read data register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rdat_r <= GPP_RD_IDLE;
        end
        else
        begin
            rdat_r <= rdat_nxt;
        end
    end

    // outputs straight from flops; latch drives the pad whenever enabled
    assign pin_out = lat_r;
    assign pin_oe  = oe_r;
    assign ana_en  = ana_r;
    assign rd_data = rdat_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    AST_OE_FOLLOWS_DIR: assert property (
        (pin_oe & dir_view) == '0
    ) else $error("driver enabled on a pin set as input");

    AST_OE_WHEN_OUTPUT: assert property (
        (~dir_view & ~pin_oe) == '0
    ) else $error("driver off on a pin set as output");

    AST_INPUT_ONLY: assert property (
        wr_en && hit_dir |=> !pin_oe[GPP_INPUT_ONLY_IDX] && dir_view[GPP_INPUT_ONLY_IDX]
    ) else $error("input-only pin driven or direction read low");

    AST_DIR_READBACK: assert property (
        rd_en && hit_dir |=> rd_data[GPP_INPUT_ONLY_IDX] == 1'b1
    ) else $error("input-only direction bit read back as zero");

    AST_PORT_READ: assert property (
        rd_en && hit_pin |=> rd_data == gpp_widen($past(pin_sync) & ~$past(ana_r))
    ) else $error("pin value read does not match sampled pins");

    AST_ANALOG_ZERO: assert property (
        rd_en && hit_pin |=> (rd_data[PIN_N-1:0] & $past(ana_r)) == '0
    ) else $error("analog pin read non-zero");

    AST_RMW_WRITE: assert property (
        wr_en && hit_pin |=>
            lat_r == gpp_merge($past(pin_rd), $past(wr_field), $past(wr_bits))
    ) else $error("port write did not merge pins and data");

    AST_RMW_ANALOG: assert property (
        wr_en && hit_pin |=> (lat_r & $past(ana_r) & ~$past(wr_bits)) == '0
    ) else $error("analog pin latch not cleared by port write");

    AST_ANALOG_DRIVES: assert property (
        wr_en && hit_dir ##1 !(wr_en && hit_dir) |=> (ana_r & ~dir_view & ~pin_oe) == '0
    ) else $error("analog select blocked a digital output");

    AST_LATCH_DIRECT: assert property (
        wr_en && hit_lat ##1 !wr_en ##1 (rd_en && hit_lat && !wr_en) |=>
            rd_data == gpp_widen($past(wr_field, 3))
    ) else $error("latch register read does not return written value");

    AST_LATCH_TO_PIN: assert property (
        wr_en && hit_lat |=> pin_out == $past(wr_field)
    ) else $error("latch write not driven to pin output");

    AST_SYNC_DELAY: assert property (
        pin_sync == $past(pin_in, 2) || $past(rst, 2) || $past(rst)
    ) else $error("pin input not delayed by two stages");

    AST_RD_ONE_CYCLE: assert property (
        !rd_en |=> rd_data == GPP_RD_IDLE
    ) else $error("read data held beyond one cycle");

    AST_RESET_ANALOG: assert property (
        $past(rst) && !rst |-> ana_r == GPP_ANA_RST && pin_oe == '0
    ) else $error("analog select not at analog mode after reset");

    AST_DIR_WRITE: assert property (
        wr_en && hit_dir |=> pin_oe == (~$past(wr_field) & ~GPP_INPUT_ONLY_MSK)
    ) else $error("direction write not reflected in driver enables");

    AST_DIR_HOLD: assert property (
        !(wr_en && hit_dir) |=> $stable(pin_oe)
    ) else $error("driver enables changed without a direction write");

    AST_OE_IGNORES_ANA: assert property (
        wr_en && hit_ana |=> $stable(pin_oe)
    ) else $error("analog select write changed a driver enable");

    AST_ANA_KEEPS_OUT: assert property (
        wr_en && hit_ana |=> $stable(pin_out)
    ) else $error("analog select write changed the driven value");

    AST_OE_INPUT_ONLY: assert property (
        pin_oe[GPP_INPUT_ONLY_IDX] == 1'b0
    ) else $error("input-only pin has its driver enabled");

    AST_DIR_READ_VALUE: assert property (
        rd_en && hit_dir |=> rd_data == gpp_widen(~$past(pin_oe))
    ) else $error("direction read does not mirror the driver enables");

    AST_RD_HIGH_ZERO: assert property (
        rd_data[GPP_DATA_W-1:PIN_N] == '0
    ) else $error("read data bits above the port width not zero");

    AST_ANA_WRITE: assert property (
        wr_en && hit_ana |=> ana_en == $past(wr_field)
    ) else $error("analog select write not stored");

    AST_ANA_HOLD: assert property (
        !(wr_en && hit_ana) |=> $stable(ana_en)
    ) else $error("analog select changed without a write");

    AST_ANA_READ: assert property (
        rd_en && hit_ana |=> rd_data == gpp_widen($past(ana_en))
    ) else $error("analog select read does not return the register");

    AST_LAT_HOLD: assert property (
        !(wr_en && (hit_pin || hit_lat)) |=> $stable(pin_out)
    ) else $error("latch changed without a port or latch write");

    AST_LAT_READ: assert property (
        rd_en && hit_lat |=> rd_data == gpp_widen($past(pin_out))
    ) else $error("latch read does not return the driven latch");

    AST_RESET_LATCH: assert property (
        $past(rst) && !rst |-> pin_out == GPP_LATCH_RST && rd_data == GPP_RD_IDLE
    ) else $error("latch or read data not at reset value after reset");

    AST_RMW_KEEP_PINS: assert property (
        wr_en && hit_pin |=> ((lat_r ^ $past(pin_sync)) & ~$past(wr_bits) & ~$past(ana_r)) == '0
    ) else $error("unaddressed digital pin level not folded into latch");

    AST_RMW_ADDRESSED: assert property (
        wr_en && hit_pin |=> ((lat_r ^ $past(wr_field)) & $past(wr_bits)) == '0
    ) else $error("addressed bits of a port write not stored");

    AST_SYNC_RESET: assert property (
        $past(rst) && !rst |-> pin_sync == '0
    ) else $error("synchroniser not cleared by reset");

    // ****************************************
    // cover points
    // ****************************************
    COV_PORT_WRITE: cover property (wr_en && hit_pin ##2 rd_en);
    COV_ANALOG_READ: cover property (rd_en && hit_pin && ana_r != '0);
    COV_DRIVE_OUT: cover property (wr_en && hit_dir && wr_field == '0 ##1 pin_oe != '0);
    COV_LATCH_READBACK: cover property (wr_en && hit_lat ##2 rd_en && hit_lat);
    COV_RMW_HAZARD: cover property (wr_en && hit_pin && (ana_r & ~dir_view) != '0);

endmodule : gpp_port

// *** gpp_board.sv ***
`timescale 1ns/1ps

// ****************************************
// board circuitry on the port pads
// ****************************************
module gpp_board
    import gpp_pkg::*;
(
    input  wire logic [gpp_pkg::GPP_PIN_N-1:0] pin_out,
    input  wire logic [gpp_pkg::GPP_PIN_N-1:0] pin_oe,
    input  wire logic [gpp_pkg::GPP_PIN_N-1:0] ext_lvl,
    output logic      [gpp_pkg::GPP_PIN_N-1:0] pin_in
);
    // a driven pad shows the port's value, a released one the board level;
    // the board always drives every pad, so a released pin never floats
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : gpp_board

// *** tb_six_bit_gpio_port.sv ***
`timescale 1ns/1ps

module tb_six_bit_gpio_port;
    import gpp_pkg::*;

    logic                  clk_sys;
    logic                  rst;
    logic [GPP_ADDR_W-1:0] addr;
    logic [GPP_DATA_W-1:0] wr_data;
    logic [GPP_PIN_N-1:0]  wr_bits;
    logic                  wr_en;
    logic                  rd_en;
    logic [GPP_DATA_W-1:0] rd_data;
    logic [GPP_PIN_N-1:0]  pin_in;
    logic [GPP_PIN_N-1:0]  pin_out;
    logic [GPP_PIN_N-1:0]  pin_oe;
    logic [GPP_PIN_N-1:0]  ana_en;
    logic [GPP_PIN_N-1:0]  ext_lvl;
    int                    err_total;
    int                    n_tests;

    gpp_port dut (
        .clk_sys (clk_sys),
        .rst     (rst),
        .addr    (addr),
        .wr_data (wr_data),
        .wr_bits (wr_bits),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .rd_data (rd_data),
        .pin_in  (pin_in),
        .pin_out (pin_out),
        .pin_oe  (pin_oe),
        .ana_en  (ana_en)
    );

    gpp_board board (
        .pin_out (pin_out),
        .pin_oe  (pin_oe),
        .ext_lvl (ext_lvl),
        .pin_in  (pin_in)
    );

    // ****************************************
    // clock and watchdog
    // ****************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // cuts a hang short after 25000 cycles, far beyond what the sequence needs
    initial
    begin
        #100000;
        err_total++;
        give_verdict();
    end

    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic [5:0] m);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= d;
        wr_bits <= m;
        wr_en   <= 1'b1;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, e);
    endtask : rd

    // idle long enough for outputs and the pin synchroniser to settle
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : idle

    task automatic give_verdict();
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        err_total = 0;
        n_tests   = 0;
        rst       = 1'b1;
        addr      = 2'h0;
        wr_data   = 8'h00;
        wr_bits   = 6'h00;
        wr_en     = 1'b0;
        rd_en     = 1'b0;
        ext_lvl   = 6'h3F;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        idle(3);
        chk({2'h0, pin_oe}, 8'h00);
        chk({2'h0, ana_en}, 8'h3F);
        rd(GPP_OFS_DIRECTION, 8'h3F);
        rd(GPP_OFS_ANA_SEL, 8'h3F);
        rd(GPP_OFS_OUT_LATCH, 8'h00);
        rd(GPP_OFS_PIN_VALUE, 8'h00);
        idle(1);
        chk(rd_data, 8'h00);
        // digital mode, all pins outputs except the input-only one
        wr(GPP_OFS_ANA_SEL, 8'h00, 6'h00);
        wr(GPP_OFS_DIRECTION, 8'h00, 6'h00);
        wr(GPP_OFS_OUT_LATCH, 8'h15, 6'h00);
        rd(GPP_OFS_OUT_LATCH, 8'h15);
        idle(4);
        chk({2'h0, pin_oe}, 8'h37);
        chk({2'h0, pin_out}, 8'h15);
        rd(GPP_OFS_DIRECTION, 8'h08);
        rd(GPP_OFS_PIN_VALUE, 8'h1D);
        rd(GPP_OFS_OUT_LATCH, 8'h15);
        // all inputs, then a masked port write folds pin levels into the latch
        ext_lvl <= 6'h25;
        wr(GPP_OFS_DIRECTION, 8'h3F, 6'h00);
        idle(4);
        chk({2'h0, pin_oe}, 8'h00);
        rd(GPP_OFS_PIN_VALUE, 8'h25);
        wr(GPP_OFS_PIN_VALUE, 8'h0A, 6'h0F);
        rd(GPP_OFS_OUT_LATCH, 8'h2A);
        // analog pins driven as outputs on purpose, to expose the hazard
        wr(GPP_OFS_ANA_SEL, 8'h03, 6'h00);
        wr(GPP_OFS_DIRECTION, 8'h3C, 6'h00);
        idle(4);
        chk({2'h0, pin_oe}, 8'h03);
        chk({2'h0, ana_en}, 8'h03);
        chk({2'h0, pin_out}, 8'h2A);
        rd(GPP_OFS_PIN_VALUE, 8'h24);
        wr(GPP_OFS_PIN_VALUE, 8'h10, 6'h10);
        idle(2);
        chk({2'h0, pin_out}, 8'h34);
        rd(GPP_OFS_OUT_LATCH, 8'h34);
        wr(GPP_OFS_DIRECTION, 8'h3F, 6'h00);
        idle(2);
        chk({2'h0, pin_oe}, 8'h00);
        give_verdict();
    end
endmodule : tb_six_bit_gpio_port
